// file: vcsr_regs.svh
`ifndef VCSR_REGS_SVH
`define VCSR_REGS_SVH
// crtc index space offsets
`define VCSR_SPLIT_LOW_IDX   8'h18
`define VCSR_RPT0_IDX        8'h19
`define VCSR_RPT1_IDX        8'h1a
`define VCSR_FIFO_LOW_IDX    8'h1b
`define VCSR_RPT3_IDX        8'h1c
`define VCSR_LATCH_MIR_IDX   8'h22
`define VCSR_ATTR_FF_IDX     8'h24
`define VCSR_ATTR_IDX_IDX    8'h26
// reset values
`define VCSR_RPT0_RST        8'h00
`define VCSR_RPT1_RST        8'h3f
`define VCSR_FIFO_LOW_RST    8'h20
`define VCSR_RPT3_RST        8'h00
`define VCSR_SPLIT_LOW_RST   8'hff
// unlock key for the extension registers
`define VCSR_UNLOCK_KEY      8'h57
// repaint control one fields
`define VCSR_R1_HS_OFF       7
`define VCSR_R1_VS_OFF       6
`define VCSR_R1_COMPAT       4
`define VCSR_R1_SIXBIT       1
`define VCSR_R1_WRAP         0
`define VCSR_R1_FORCED       8'h28
// repaint control three fields
`define VCSR_R3_FONTLD       7
`define VCSR_R3_SEQC4        2
`define VCSR_R3_PGSEL        1
`define VCSR_R3_OVLP         0
// memory map select encodings
`define VCSR_MAP_128K        2'b00
`define VCSR_MAP_64K         2'b01
`endif

// file: vcsr_pkg.sv
package vcsr_pkg;
  // host cycle kind, gray along idle->read->write
  typedef enum logic [1:0]
  {
    VCSR_IDLE  = 2'b00,
    VCSR_READ  = 2'b01,
    VCSR_WRITE = 2'b11
  } vcsr_cycle_t;
  typedef logic [7:0] vcsr_byte_t;
endpackage : vcsr_pkg

// file: vcsr_host_remap.sv
`timescale 1ns/1ps
`include "vcsr_regs.svh"
// host address warp and paging, purely combinational
module vcsr_host_remap
  import vcsr_pkg::*;
(
  input  wire logic [16:0] host_addr,
  input  wire logic        host_rd,
  input  wire logic [7:0]  rpt3,
  input  wire logic [1:0]  map_sel,
  input  wire logic        chain4,
  input  wire logic [6:0]  page0,
  input  wire logic [6:0]  page1,
  output logic      [21:0] fb_addr,
  output logic             page_pick
);
  logic [15:0] off;
  logic        seq;
  logic [6:0]  pg;
  logic [21:0] base;
  always_comb
  begin
    off = host_addr[15:0];
    seq = rpt3[`VCSR_R3_SEQC4] & chain4;
    // font load warp into plane 2
    if (rpt3[`VCSR_R3_FONTLD])
      off = {host_addr[4:0], host_addr[15:5]};
    // page choice: address bit or cycle type
    if (rpt3[`VCSR_R3_PGSEL])
      page_pick = (map_sel == `VCSR_MAP_128K) ? host_addr[16]
                                              : host_addr[15];
    else
      page_pick = ~host_rd;
    pg = page_pick ? page1 : page0;
    // sequential chain-4 pages are 8k, others 32k
    if (seq)
      base = {2'b00, pg, 13'h0000} + {6'h00, off};
    else
      base = {pg, 15'h0000} + {6'h00, off};
    fb_addr = base;
    // overlapped paging adds 64k in the 128k map, 32k in the 64k map and nothing in other maps; four times that when not sequential chain-4
    if (rpt3[`VCSR_R3_OVLP])
    begin
      if (seq)
      begin
        if (map_sel == `VCSR_MAP_128K)
          fb_addr = base + 22'h010000;
        else if (map_sel == `VCSR_MAP_64K)
          fb_addr = base + 22'h008000;
      end
      else
      begin
        if (map_sel == `VCSR_MAP_128K)
          fb_addr = base + 22'h040000;
        else if (map_sel == `VCSR_MAP_64K)
          fb_addr = base + 22'h020000;
      end
    end
  end
endmodule : vcsr_host_remap

// file: vcsr_crtc_ext.sv
`timescale 1ns/1ps
`include "vcsr_regs.svh"
module vcsr_crtc_ext
  import vcsr_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  reg_idx,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        unlock_wr,
  input  wire logic [7:0]  unlock_data,
  input  wire logic        split_bit8,
  input  wire logic        split_bit9,
  input  wire logic [10:0] vert_total,
  input  wire logic [10:0] scan_line,
  input  wire logic        line_start,
  input  wire logic [15:0] start_addr_low,
  input  wire logic [7:0]  offset_low,
  input  wire logic [4:0]  smooth_scroll,
  input  wire logic        pan_lower,
  input  wire logic [31:0] gfx_latches,
  input  wire logic [1:0]  read_map,
  input  wire logic        attr_ff,
  input  wire logic [5:0]  attr_index,
  input  wire logic        hsync_raw,
  input  wire logic        vsync_raw,
  input  wire logic        hsync_pol,
  input  wire logic        vsync_pol,
  input  wire logic [7:0]  fifo_level,
  input  wire logic        fifo_underflow,
  input  wire logic [21:0] refresh_addr,
  input  wire logic [16:0] host_addr,
  input  wire logic        host_rd,
  input  wire logic        host_wr,
  input  wire logic [1:0]  map_sel,
  input  wire logic        chain4,
  input  wire logic [6:0]  page0,
  input  wire logic [6:0]  page1,
  output logic             split_clear,
  output logic             lower_region,
  output logic [19:0]      fetch_start,
  output logic [9:0]       line_offset,
  output logic [4:0]       scroll_eff,
  output logic             pan_eff,
  output logic             hsync_out,
  output logic             vsync_out,
  output logic             font_warp,
  output logic             six_bit_pal,
  output logic [21:0]      refresh_out,
  output logic             refill_req,
  output logic [21:0]      fb_addr,
  output logic             fb_page
);
  logic [7:0]  split_low_q;
  logic [7:0]  rpt0_q;
  logic [7:0]  rpt1_q;
  logic [4:0]  low_mark_q;
  logic [1:0]  uflow_q;
  logic [7:0]  rpt3_q;
  logic        unlocked_q;
  logic [21:0] remap_addr;
  logic        remap_page;
  logic [9:0]  split_val;
  logic        split_on;
  logic        ext_idx;
  logic        wr_ok;
  vcsr_byte_t  rd_d;
  vcsr_cycle_t cyc_q;

  assign split_val = {split_bit9, split_bit8, split_low_q};
  // values above the vertical total never match, so split is off
  assign split_on  = {1'b0, split_val} <= vert_total;
  assign ext_idx   = (reg_idx == `VCSR_RPT0_IDX) ||
                     (reg_idx == `VCSR_RPT1_IDX) ||
                     (reg_idx == `VCSR_FIFO_LOW_IDX) ||
                     (reg_idx == `VCSR_RPT3_IDX);
  // locked extension writes are dropped, reads return zero
  assign wr_ok     = reg_wr & (~ext_idx | unlocked_q);

  // unlock latch follows every write to the unlock register
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      unlocked_q <= 1'b0;
    else if (unlock_wr)
      unlocked_q <= (unlock_data == `VCSR_UNLOCK_KEY);
  end

  // split compare low byte, standard register, always reachable
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      split_low_q <= `VCSR_SPLIT_LOW_RST;
    else if (wr_ok && reg_idx == `VCSR_SPLIT_LOW_IDX)
      split_low_q <= reg_wdata;
  end

  // repaint controls zero, one and three
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rpt0_q <= `VCSR_RPT0_RST;
      rpt1_q <= `VCSR_RPT1_RST;
      rpt3_q <= `VCSR_RPT3_RST;
    end
    else if (wr_ok)
    begin
      if (reg_idx == `VCSR_RPT0_IDX)
        rpt0_q <= {2'b00, reg_wdata[5:0]};
      else if (reg_idx == `VCSR_RPT1_IDX)
        rpt1_q <= reg_wdata | `VCSR_R1_FORCED;
      else if (reg_idx == `VCSR_RPT3_IDX)
        rpt3_q <= {reg_wdata[7], 4'h0, reg_wdata[2:0]};
    end
  end

  // low mark and underflow flags; a new underflow beats the clear
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      low_mark_q <= 5'(`VCSR_FIFO_LOW_RST >> 3);
      uflow_q    <= 2'b00;
    end
    else
    begin
      if (wr_ok && reg_idx == `VCSR_FIFO_LOW_IDX)
        low_mark_q <= reg_wdata[7:3];
      if (fifo_underflow)
        uflow_q <= 2'b11;
      else if (wr_ok && reg_idx == `VCSR_FIFO_LOW_IDX)
        uflow_q <= 2'b00;
    end
  end

  // read mux, if-chain decode
  always_comb
  begin
    rd_d = 8'h00;
    if (reg_idx == `VCSR_SPLIT_LOW_IDX)
      rd_d = split_low_q;
    else if (ext_idx && !unlocked_q)
      rd_d = 8'h00;
    else if (reg_idx == `VCSR_RPT0_IDX)
      rd_d = rpt0_q;
    else if (reg_idx == `VCSR_RPT1_IDX)
      rd_d = rpt1_q;
    else if (reg_idx == `VCSR_FIFO_LOW_IDX)
      rd_d = {low_mark_q, 1'b0, uflow_q};
    else if (reg_idx == `VCSR_RPT3_IDX)
      rd_d = rpt3_q;
    else if (reg_idx == `VCSR_LATCH_MIR_IDX)
      rd_d = gfx_latches[{read_map, 3'b000} +: 8];
    else if (reg_idx == `VCSR_ATTR_FF_IDX)
      rd_d = {attr_ff, 7'h00};
    else if (reg_idx == `VCSR_ATTR_IDX_IDX)
      rd_d = {2'b00, attr_index};
  end

  // read data registered; held between reads
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rd_d;
  end

  // split detection and region tracking
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      split_clear  <= 1'b0;
      lower_region <= 1'b0;
    end
    else
    begin
      split_clear <= split_on && line_start &&
                     (scan_line == {1'b0, split_val});
      if (line_start && scan_line == 11'h000)
        lower_region <= 1'b0;
      else if (split_on && line_start &&
               scan_line == {1'b0, split_val})
        lower_region <= 1'b1;
    end
  end

  // fetch start, scroll and panning per region; line offset the same in both regions
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      fetch_start <= 20'h00000;
      line_offset <= 10'h000;
      scroll_eff  <= 5'h00;
      pan_eff     <= 1'b0;
    end
    else
    begin
      fetch_start <= lower_region ? 20'h00000
                     : {rpt0_q[3:0], start_addr_low};
      line_offset <= {rpt0_q[5:4], offset_low};
      scroll_eff  <= lower_region ? 5'h00 : smooth_scroll;
      pan_eff     <= ~lower_region | pan_lower;
    end
  end

  // sync forcing: polarity inputs already give the inactive level
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      hsync_out <= 1'b0;
      vsync_out <= 1'b0;
    end
    else
    begin
      hsync_out <= rpt1_q[`VCSR_R1_HS_OFF] ? hsync_pol
                   : hsync_raw;
      vsync_out <= rpt1_q[`VCSR_R1_VS_OFF] ? vsync_pol
                   : vsync_raw;
    end
  end

  // text, palette, wrap and refill controls
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      font_warp   <= 1'b0;
      six_bit_pal <= 1'b1;
      refresh_out <= 22'h000000;
      refill_req  <= 1'b0;
    end
    else
    begin
      font_warp   <= ~rpt1_q[`VCSR_R1_COMPAT];
      six_bit_pal <= rpt1_q[`VCSR_R1_SIXBIT];
      refresh_out <= rpt1_q[`VCSR_R1_WRAP]
                     ? {6'h00, refresh_addr[15:0]}
                     : refresh_addr;
      // twice the mark, widened so a large mark cannot wrap
      refill_req  <= {1'b0, fifo_level} <
                     {3'b000, low_mark_q, 1'b0};
    end
  end

  // host cycle kind remembered for the page choice output
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      cyc_q <= VCSR_IDLE;
    else
    begin
      case (cyc_q)
        VCSR_IDLE:  cyc_q <= host_rd ? VCSR_READ
                             : (host_wr ? VCSR_WRITE : VCSR_IDLE);
        VCSR_READ:  cyc_q <= host_wr ? VCSR_WRITE
                             : (host_rd ? VCSR_READ : VCSR_IDLE);
        VCSR_WRITE: cyc_q <= host_rd ? VCSR_READ
                             : (host_wr ? VCSR_WRITE : VCSR_IDLE);
        default:    cyc_q <= VCSR_IDLE;
      endcase
    end
  end

  vcsr_host_remap u_remap
  (
    .host_addr (host_addr),
    .host_rd   (host_rd | cyc_q == VCSR_READ & ~host_wr),
    .rpt3      (rpt3_q),
    .map_sel   (map_sel),
    .chain4    (chain4),
    .page0     (page0),
    .page1     (page1),
    .fb_addr   (remap_addr),
    .page_pick (remap_page)
  );

  // registered host frame buffer address
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      fb_addr <= 22'h000000;
      fb_page <= 1'b0;
    end
    else
    begin
      fb_addr <= remap_addr;
      fb_page <= remap_page;
    end
  end

  // checks
  split_clr_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    line_start && split_on && scan_line == {1'b0, split_val}
    |=> split_clear) else $error("split clear missing");
  lower_fetch_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    lower_region |=> fetch_start == 20'h00000)
    else $error("lower fetch not zero");
  lower_scroll_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    lower_region |=> scroll_eff == 5'h00)
    else $error("lower region scrolled");
  split_off_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    {1'b0, split_val} > vert_total |=> !split_clear)
    else $error("split fired while off");
  latch_read_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_rd && reg_idx == `VCSR_LATCH_MIR_IDX
    |=> reg_rdata == $past(gfx_latches[{read_map, 3'b000} +: 8]))
    else $error("latch mirror wrong");
  ff_read_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_rd && reg_idx == `VCSR_ATTR_FF_IDX
    |=> reg_rdata == {$past(attr_ff), 7'h00})
    else $error("flip-flop mirror wrong");
  idx_read_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_rd && reg_idx == `VCSR_ATTR_IDX_IDX
    |=> reg_rdata[7:6] == 2'b00)
    else $error("index mirror top bits set");
  lock_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !unlocked_q && reg_wr && reg_idx == `VCSR_RPT3_IDX
    |=> $stable(rpt3_q)) else $error("locked write took");
  rsvd_one_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    rpt1_q[5] && rpt1_q[3]) else $error("reserved ones lost");
  hs_force_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    rpt1_q[`VCSR_R1_HS_OFF] ##1 rpt1_q[`VCSR_R1_HS_OFF]
    |-> hsync_out == $past(hsync_pol))
    else $error("hsync not held");
  uflow_set_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    fifo_underflow |=> uflow_q == 2'b11)
    else $error("underflow lost");
  wrap_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    rpt1_q[`VCSR_R1_WRAP] |=> refresh_out[21:16] == 6'h00)
    else $error("wrap not applied");
  split_cv: cover property (@(posedge sys_clk) disable iff (!nrst)
    split_clear ##[1:100] lower_region);
  unlock_cv: cover property (@(posedge sys_clk) disable iff (!nrst)
    unlocked_q && reg_wr && reg_idx == `VCSR_RPT3_IDX);
  uflow_cv: cover property (@(posedge sys_clk) disable iff (!nrst)
    uflow_q == 2'b11 ##1 uflow_q == 2'b00);
endmodule : vcsr_crtc_ext

// file: tb_top.sv
`timescale 1ns/1ps
`include "vcsr_regs.svh"
module tb_top
  import vcsr_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  reg_idx = 8'h00, reg_wdata = 8'h00, unlock_data = 8'h00;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, unlock_wr = 1'b0;
  logic        split_bit8 = 1'b0, split_bit9 = 1'b0, line_start = 1'b0;
  logic [10:0] vert_total = 11'h020, scan_line = 11'h000;
  logic [15:0] start_addr_low = 16'h1234;
  logic [7:0]  offset_low = 8'h9a, fifo_level = 8'h80;
  logic [4:0]  smooth_scroll = 5'h0a;
  logic        pan_lower = 1'b1, attr_ff = 1'b0, fifo_underflow = 1'b0;
  logic [31:0] gfx_latches = 32'h44332211;
  logic [1:0]  read_map = 2'h0, map_sel = 2'h0;
  logic [5:0]  attr_index = 6'h2a;
  logic        hsync_raw = 1'b0, vsync_raw = 1'b1;
  logic        hsync_pol = 1'b1, vsync_pol = 1'b0;
  logic [21:0] refresh_addr = 22'h3fffff;
  logic [16:0] host_addr = 17'h00123;
  logic        host_rd = 1'b1, host_wr = 1'b0, chain4 = 1'b0;
  logic [6:0]  page0 = 7'h02, page1 = 7'h05;
  logic [7:0]  reg_rdata;
  logic        split_clear, lower_region, pan_eff, hsync_out, vsync_out;
  logic        font_warp, six_bit_pal, refill_req, fb_page;
  logic [19:0] fetch_start;
  logic [9:0]  line_offset;
  logic [4:0]  scroll_eff;
  logic [21:0] refresh_out, fb_addr;
  int          fails = 0, samples_checked = 0;
  vcsr_byte_t  rd;

  vcsr_crtc_ext i_vcsr_crtc_ext (.sys_clk(sys_clk), .nrst(nrst),
    .reg_idx(reg_idx), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .unlock_wr(unlock_wr),
    .unlock_data(unlock_data), .split_bit8(split_bit8),
    .split_bit9(split_bit9), .vert_total(vert_total),
    .scan_line(scan_line), .line_start(line_start),
    .start_addr_low(start_addr_low), .offset_low(offset_low),
    .smooth_scroll(smooth_scroll), .pan_lower(pan_lower),
    .gfx_latches(gfx_latches), .read_map(read_map), .attr_ff(attr_ff),
    .attr_index(attr_index), .hsync_raw(hsync_raw),
    .vsync_raw(vsync_raw), .hsync_pol(hsync_pol), .vsync_pol(vsync_pol),
    .fifo_level(fifo_level), .fifo_underflow(fifo_underflow),
    .refresh_addr(refresh_addr), .host_addr(host_addr),
    .host_rd(host_rd), .host_wr(host_wr), .map_sel(map_sel),
    .chain4(chain4), .page0(page0), .page1(page1),
    .split_clear(split_clear), .lower_region(lower_region),
    .fetch_start(fetch_start), .line_offset(line_offset),
    .scroll_eff(scroll_eff), .pan_eff(pan_eff), .hsync_out(hsync_out),
    .vsync_out(vsync_out), .font_warp(font_warp),
    .six_bit_pal(six_bit_pal), .refresh_out(refresh_out),
    .refill_req(refill_req), .fb_addr(fb_addr), .fb_page(fb_page));

  // 100 ns period
  always #50 sys_clk = ~sys_clk;

  task automatic chk(input logic [21:0] exp, input logic [21:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : chk

  // registered outputs need a couple of edges to settle
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : step

  task automatic reg_write(input logic [7:0] i, input logic [7:0] d);
    @(posedge sys_clk);
    reg_idx   <= i;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask : reg_write

  // data is taken one edge after the read strobe
  task automatic reg_read(input logic [7:0] i, output vcsr_byte_t d);
    @(posedge sys_clk);
    reg_idx <= i;
    reg_rd  <= 1'b1;
    @(posedge sys_clk);
    reg_rd  <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : reg_read

  task automatic unlock(input logic [7:0] d);
    @(posedge sys_clk);
    unlock_data <= d;
    unlock_wr   <= 1'b1;
    @(posedge sys_clk);
    unlock_wr   <= 1'b0;
  endtask : unlock

  task automatic t_lock;
    reg_write(8'h1c, 8'h04);
    reg_read(8'h1a, rd); chk(8'h00, rd);
    unlock(8'h57);
    reg_read(8'h1c, rd); chk(8'h00, rd);
    reg_read(8'h19, rd); chk(8'h00, rd);
    reg_read(8'h1a, rd); chk(8'h3f, rd);
    reg_read(8'h1b, rd); chk(8'h20, rd);
    reg_read(8'h30, rd); chk(8'h00, rd);
    unlock(8'h00);
    reg_read(8'h1a, rd); chk(8'h00, rd);
    unlock(8'h57);
    $display("test lock done");
  endtask : t_lock

  task automatic t_ctl;
    reg_write(8'h19, 8'h35);
    step(3);
    chk(10'h39a, line_offset);
    chk(20'h51234, fetch_start);
    reg_write(8'h1a, 8'hc0);
    step(3);
    chk(1'b1, hsync_out);
    chk(1'b0, vsync_out);
    chk(1'b0, six_bit_pal);
    chk(1'b1, font_warp);
    chk(22'h3fffff, refresh_out);
    reg_read(8'h1a, rd); chk(8'he8, rd);
    reg_write(8'h1a, 8'h13);
    step(3);
    chk(1'b1, six_bit_pal);
    chk(1'b0, font_warp);
    chk(22'h00ffff, refresh_out);
    chk(1'b0, hsync_out);
    chk(1'b1, vsync_out);
    reg_write(8'h1a, 8'h3e);
    $display("test control done");
  endtask : t_ctl

  // low mark field 9 gives a threshold of 18
  task automatic t_fifo;
    reg_write(8'h1b, 8'h48);
    @(posedge sys_clk);
    fifo_level <= 8'd17;
    step(3);
    chk(1'b1, refill_req);
    @(posedge sys_clk);
    fifo_level <= 8'd18;
    step(3);
    chk(1'b0, refill_req);
    @(posedge sys_clk);
    fifo_underflow <= 1'b1;
    @(posedge sys_clk);
    fifo_underflow <= 1'b0;
    reg_read(8'h1b, rd); chk(8'h4b, rd);
    reg_write(8'h1b, 8'h48);
    reg_read(8'h1b, rd); chk(8'h48, rd);
    $display("test fifo done");
  endtask : t_fifo

  task automatic line(input logic [10:0] s);
    @(posedge sys_clk);
    scan_line  <= s;
    line_start <= 1'b1;
    @(posedge sys_clk);
    line_start <= 1'b0;
    #1;
  endtask : line

  task automatic t_split;
    reg_write(8'h18, 8'h10);
    line(11'h010);
    chk(1'b1, split_clear);
    chk(1'b1, lower_region);
    step(3);
    chk(20'h00000, fetch_start);
    chk(5'h00, scroll_eff);
    // lower region pans only when the mode bit allows it
    @(posedge sys_clk);
    pan_lower <= 1'b0;
    step(2);
    chk(1'b0, pan_eff);
    line(11'h000);
    step(3);
    chk(1'b0, lower_region);
    chk(5'h0a, scroll_eff);
    chk(1'b1, pan_eff);
    @(posedge sys_clk);
    pan_lower  <= 1'b1;
    vert_total <= 11'h00f;
    line(11'h010);
    chk(1'b0, split_clear);
    chk(1'b0, lower_region);
    // upper compare bits come from the other crtc registers
    @(posedge sys_clk);
    vert_total <= 11'h3ff;
    split_bit8 <= 1'b1;
    split_bit9 <= 1'b1;
    line(11'h010);
    chk(1'b0, split_clear);
    line(11'h310);
    chk(1'b1, split_clear);
    $display("test split done");
  endtask : t_split

  task automatic t_mirror;
    for (int m = 0; m < 4; m++)
    begin
      @(posedge sys_clk);
      read_map <= m[1:0];
      reg_read(8'h22, rd); chk(gfx_latches[8*m +: 8], rd);
    end
    @(posedge sys_clk);
    attr_ff <= 1'b1;
    reg_read(8'h24, rd); chk(8'h80, rd);
    @(posedge sys_clk);
    attr_ff <= 1'b0;
    reg_read(8'h24, rd); chk(8'h00, rd);
    reg_read(8'h26, rd); chk(8'h2a, rd);
    $display("test mirror done");
  endtask : t_mirror

  // applies one host setting and checks address and page
  task automatic hchk(input logic [7:0] c3, input logic [1:0] ms,
                      input logic c4, input logic [16:0] ha,
                      input logic [21:0] ea, input logic ep);
    reg_write(8'h1c, c3);
    map_sel   <= ms;
    chain4    <= c4;
    host_addr <= ha;
    step(3);
    chk(ea, fb_addr);
    chk(ep, fb_page);
  endtask : hchk

  task automatic t_host;
    hchk(8'h00, 2'b00, 1'b0, 17'h00123, 22'h010123, 1'b0);
    hchk(8'h01, 2'b00, 1'b0, 17'h00123, 22'h050123, 1'b0);
    hchk(8'h01, 2'b01, 1'b0, 17'h00123, 22'h030123, 1'b0);
    hchk(8'h05, 2'b00, 1'b1, 17'h00123, 22'h014123, 1'b0);
    hchk(8'h05, 2'b01, 1'b1, 17'h00123, 22'h00c123, 1'b0);
    hchk(8'h04, 2'b00, 1'b0, 17'h00123, 22'h010123, 1'b0);
    hchk(8'h80, 2'b00, 1'b0, 17'h00123, 22'h011809, 1'b0);
    @(posedge sys_clk);
    host_rd <= 1'b0;
    host_wr <= 1'b1;
    // font load order: chain-4 off, bit set, writes, bit cleared
    hchk(8'h80, 2'b00, 1'b0, 17'h00123, 22'h029809, 1'b1);
    hchk(8'h00, 2'b00, 1'b0, 17'h00123, 22'h028123, 1'b1);
    hchk(8'h02, 2'b00, 1'b0, 17'h10123, 22'h028123, 1'b1);
    hchk(8'h02, 2'b01, 1'b0, 17'h08123, 22'h030123, 1'b1);
    $display("test host done");
  endtask : t_host

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  // whole run is under two hundred cycles
  initial
  begin
    #1000000;
    fails++;
    report_and_stop();
  end

  // main sequence
  initial
  begin
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    t_lock();
    t_ctl();
    t_fifo();
    t_split();
    t_mirror();
    t_host();
    report_and_stop();
  end
endmodule : tb_top
